// ### tb_window_watchdog_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module tb_window_watchdog_supervisor
	import wws_pkg::*;
;
	localparam int unsigned SC = 2000;
	localparam int unsigned LC = 4000;
	localparam int unsigned DC = 50;
	localparam int unsigned CB = 200;
	logic clk, arst_n, supplyOk, tSel, capMode, rSel, trig, rst_n, tmo, early, capErr;
	logic [31:0] capFf;
	logic [15:0] gap;
	int fail_count, checks, seed, up, lo, i;
	wws_top #(.SHORT_CYCLES(SC), .LONG_CYCLES(LC), .DELAY_CYCLES(DC), .CAPBASE_CYCLES(CB)) dut_u
		(.clk(clk), .arst_n(arst_n), .supplyOk(supplyOk), .timeoutSelect(tSel),
		.capMode(capMode), .capFf(capFf), .ratioSelect(rSel), .triggerInput(trig),
		.resetOut_n(rst_n), .timeoutFlag(tmo), .earlyFlag(early), .capRangeErr(capErr));
	wws_proc_model u_proc (.clk(clk), .resetOut_n(rst_n), .gap(gap), .trig(trig));
	function automatic int upper_of(input logic c, input logic t, input int cap);
		return c ? cap * CB / CAP_UNIT_FF + CB : (t ? LC : SC);
	endfunction : upper_of
	function automatic int lower_of(input logic c, input logic t, input logic r, input int u);
		return u * 10 / (c ? (r ? RAT_CAP_HI : RAT_CAP_LO) :
			t ? (r ? RAT_LONG_HI : RAT_LONG_LO) : (r ? RAT_SHORT_HI : RAT_SHORT_LO));
	endfunction : lower_of
	task automatic chk(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask : chk
	task automatic wait_on(input int k, input int lim);
		int n;
		n = 0;
		while (n < lim && (k == 0 ? rst_n : k == 1 ? early : tmo) !== 1'b1)
		begin
			@(posedge clk);
			n++;
		end
		#1;
	endtask : wait_on
	task automatic stop_test;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		fail_count++;
		stop_test();
	end
	initial
	begin
		{seed, fail_count, checks} = {32'hadda, 64'h0};
		{arst_n, supplyOk, tSel, rSel, capMode, capFf, gap} = {1'b0, 1'b1, 51'h0};
		repeat (10) @(posedge clk);
		#1 arst_n = 1'b1;
		wait_on(0, DC + 10);
		chk("release", 1'b1, rst_n);
		for (i = 0; i < 6; i++)
		begin
			// Two capacitor-mode passes follow the four strap combinations
			{supplyOk, capMode, tSel, capFf} = {1'b0, 1'b1, i[0], 32'h000186A0};
			rSel = (i == 5) ? 1'b1 : i[1];
			@(posedge clk);
			#1 chk("cap low", 1'b1, capErr);
			chk("supply low", 1'b0, rst_n);
			capFf = 32'h00025F90 + {16'h0, 16'($random(seed))};
			@(posedge clk);
			#1 chk("cap ok", 1'b0, capErr);
			capMode = i[2];
			up = upper_of(i[2], i[0], capFf);
			lo = lower_of(i[2], i[0], rSel, up);
			repeat (2) @(posedge clk);
			#1 supplyOk = 1'b1;
			wait_on(0, DC + 10);
			chk("return", 1'b1, rst_n);
			// First edge comes early on purpose; lower check is still off
			gap = 16'(lo / 2);
			repeat (lo / 2 + 4) @(posedge clk);
			gap = 16'(lo + (up - lo) / 4 + $unsigned($random(seed)) % ((up - lo) / 2));
			repeat (3 * gap + 8) @(posedge clk);
			#1 chk("in window", 1'b1, rst_n);
			chk("no early", 1'b0, early);
			gap = 16'(lo / 2);
			wait_on(1, up);
			chk("early", 1'b1, early);
			chk("early rst", 1'b0, rst_n);
			gap = 16'h0;
			wait_on(0, DC + 10);
			chk("restart", 1'b1, rst_n);
			wait_on(2, up + 10);
			chk("timeout", 1'b1, tmo);
			chk("tmo rst", 1'b0, rst_n);
		end
		stop_test();
	end
endmodule : tb_window_watchdog_supervisor
`default_nettype wire

// ### wws_pkg.sv
// What this block does
// - Reset undefined below power-on; nothing relies
// - Supply below trip threshold forces reset low
// - Above threshold, last trigger timing decides reset
// - Triggers inside window keep reset high
// - Early or missing trigger drives reset low
// - Two straps select four capacitor-free timings
// - Upper limit 0.25 s low, 2.5 s high
// - Ratio high: divide by 124.9/127.7/64.5
// - Ratio low: divide by 31.8/32/25.8
// - Capacitor mode: 6.25 ms times (C/15.55pF+1)
// - Trigger edge recognised at second internal cycle, acts at third
// - Flag timeout or early violation; both reset
// - Rising or falling trigger edge retriggers
// - Missed trigger: reset for delay, restart timer
// - Lower limit off until first rising trigger
// - Supply return holds reset 25 ms
package wws_pkg;

	localparam int unsigned CLK_HZ = 20000000;
	// Times in microseconds
	localparam int unsigned T_SHORT_US = 250000;
	localparam int unsigned T_LONG_US = 2500000;
	localparam int unsigned T_DELAY_US = 25000;
	localparam int unsigned T_CAPBASE_US = 6250;
	localparam int unsigned CAP_UNIT_FF = 15550;
	localparam int unsigned CAP_MIN_FF = 155000;
	localparam int unsigned CAP_MAX_FF = 63000000;
	localparam int unsigned US_CYC = CLK_HZ / 1000000;
	localparam int unsigned SHORT_CYC = T_SHORT_US * US_CYC;
	localparam int unsigned LONG_CYC = T_LONG_US * US_CYC;
	localparam int unsigned DELAY_CYC = T_DELAY_US * US_CYC;
	// Ratios times ten
	localparam int unsigned RAT_SHORT_HI = 1249;
	localparam int unsigned RAT_LONG_HI = 1277;
	localparam int unsigned RAT_CAP_HI = 645;
	localparam int unsigned RAT_SHORT_LO = 318;
	localparam int unsigned RAT_LONG_LO = 320;
	localparam int unsigned RAT_CAP_LO = 258;
	localparam int unsigned CNT_W = 32;

	typedef enum logic [1:0]
	{
		TSEL_SHORT = 2'h0,
		TSEL_LONG = 2'h1,
		TSEL_CAP = 2'h2
	} wws_tsel_t;

	typedef enum logic [1:0]
	{
		ST_HOLD = 2'h0,
		ST_RUN = 2'h1,
		ST_FAULT = 2'h2
	} wws_state_t;

endpackage : wws_pkg

// ### wws_proc_model.sv
`timescale 1ns/100ps
`default_nettype none
module wws_proc_model
(
	// Clock, reset seen and spacing asked for
	input wire logic        clk,
	input wire logic        resetOut_n,
	input wire logic [15:0] gap,
	// Trigger
	output logic            trig
);
	logic [15:0] cnt;
	initial
	begin
		trig = 1'b0;
		cnt = 16'h0;
	end
	// Zero spacing stalls, as a hung program would
	always @(posedge clk)
	begin
		#1;
		if (!resetOut_n || gap == 16'h0)
			cnt = 16'h0;
		else if (cnt + 16'h1 >= gap)
		begin
			trig = !trig;
			cnt = 16'h0;
		end
		else
			cnt = cnt + 16'h1;
	end
endmodule : wws_proc_model
`default_nettype wire

// ### wws_sync.sv
`timescale 1ns/100ps
`default_nettype none
module wws_sync
	import wws_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Raw and synchronised level
	input  wire logic din,
	output logic      dout
);
	logic stage1Ff;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage1Ff <= 1'h0;
			dout <= 1'h0;
		end
		else
		begin
			stage1Ff <= din;
			dout <= stage1Ff;
		end
	end
endmodule : wws_sync
`default_nettype wire

// ### wws_top.sv
`timescale 1ns/100ps
`default_nettype none
module wws_top
	import wws_pkg::*;
#(
	parameter int unsigned SHORT_CYCLES = SHORT_CYC,
	parameter int unsigned LONG_CYCLES = LONG_CYC,
	parameter int unsigned DELAY_CYCLES = DELAY_CYC,
	parameter int unsigned CAPBASE_CYCLES = T_CAPBASE_US * US_CYC
)
(
	// Clock and power-on reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Supply comparator: high while supply above trip threshold
	input  wire logic        supplyOk,
	// Watchdog straps
	input  wire logic        timeoutSelect,
	input  wire logic        capMode,
	input  wire logic [31:0] capFf,
	input  wire logic        ratioSelect,
	// Watchdog trigger and reset
	input  wire logic        triggerInput,
	output logic             resetOut_n,
	output logic             timeoutFlag,
	output logic             earlyFlag,
	output logic             capRangeErr
);
	// Below these counts the synchroniser delay eats the whole window
	if (SHORT_CYCLES < 64 || LONG_CYCLES < 64 || DELAY_CYCLES < 1 || CAPBASE_CYCLES < 64
		|| 64'(CAP_MAX_FF / CAP_UNIT_FF + 1) * 64'(CAPBASE_CYCLES) >= 64'h0000000100000000)
	begin : gBadCounts
		$error("wws_top: counts out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Limits from straps; ratios are kept times ten to stay in integers

	function automatic logic [CNT_W-1:0] lowerOf(input logic [CNT_W-1:0] upper,
		input wws_tsel_t sel, input logic ratHi);
		logic [63:0] r;
		r = 64'h0;
		case (sel)
			TSEL_SHORT: r = 64'(ratHi ? RAT_SHORT_HI : RAT_SHORT_LO);
			TSEL_LONG:  r = 64'(ratHi ? RAT_LONG_HI : RAT_LONG_LO);
			TSEL_CAP:   r = 64'(ratHi ? RAT_CAP_HI : RAT_CAP_LO);
			default:    r = 64'(RAT_SHORT_LO);
		endcase
		return CNT_W'((64'(upper) * 64'h000000000000000A) / r);
	endfunction : lowerOf

	wws_tsel_t         tsel;
	logic [CNT_W-1:0]  upperCnt;
	logic [CNT_W-1:0]  lowerCnt;
	logic [63:0]       capProd;

	always_comb
	begin
		tsel = capMode ? TSEL_CAP : (timeoutSelect ? TSEL_LONG : TSEL_SHORT);
		capProd = (64'(capFf) * 64'(CAPBASE_CYCLES)) / 64'(CAP_UNIT_FF)
			+ 64'(CAPBASE_CYCLES);
		case (tsel)
			TSEL_SHORT: upperCnt = CNT_W'(SHORT_CYCLES);
			TSEL_LONG:  upperCnt = CNT_W'(LONG_CYCLES);
			TSEL_CAP:   upperCnt = CNT_W'(capProd);
			default:    upperCnt = CNT_W'(SHORT_CYCLES);
		endcase
		lowerCnt = lowerOf(upperCnt, tsel, ratioSelect);
	end

	// Range error is only reported; timing still follows the given value
	logic capBad;

	assign capBad = capMode && (capFf <= CAP_MIN_FF || capFf >= CAP_MAX_FF);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			capRangeErr <= 1'b0;
		else
			capRangeErr <= capBad;
	end

	////////////////////////////////////////////////////////////////////////
	// Trigger path

	logic trigSync;
	logic trigPrevFf;
	logic anyEdge;
	logic riseEdge;

	// Two flops: the trigger comes from a clock unrelated to ours
	wws_sync uSync
	(
		.clk    (clk),
		.arst_n (arst_n),
		.din    (triggerInput),
		.dout   (trigSync)
	);

	// Reset level low matches the pulled-down idle level of the trigger pin
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			trigPrevFf <= 1'h0;
		else
			trigPrevFf <= trigSync;
	end

	// Edge acts one cycle after capture, never combinationally
	assign anyEdge = trigSync ^ trigPrevFf;
	assign riseEdge = trigSync & ~trigPrevFf;

	////////////////////////////////////////////////////////////////////////
	// Window state machine

	wws_state_t       state_ff;
	wws_state_t       nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic             lowerEn_ff;
	logic             nxt_lowerEn;
	logic             isTimeout;
	logic             isEarly;

	// Decided one count early: the output flop adds the last cycle
	assign isTimeout = (state_ff == ST_RUN) && !anyEdge && (cnt_ff >= upperCnt - 1);
	assign isEarly = (state_ff == ST_RUN) && anyEdge && lowerEn_ff && (cnt_ff < lowerCnt);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff + 1'b1;
		nxt_lowerEn = lowerEn_ff;
		case (state_ff)
			ST_HOLD, ST_FAULT:
			begin
				// Every release starts a first window without lower check
				nxt_lowerEn = 1'b0;
				if (cnt_ff >= CNT_W'(DELAY_CYCLES - 1))
				begin
					nxt_state = ST_RUN;
					nxt_cnt = '0;
				end
			end
			ST_RUN:
			begin
				if (isTimeout || isEarly)
				begin
					nxt_state = ST_FAULT;
					nxt_cnt = '0;
				end
				else if (anyEdge)
				begin
					nxt_cnt = '0;
					if (riseEdge)
						nxt_lowerEn = 1'b1;
				end
			end
			default:
			begin
				nxt_state = ST_HOLD;
				nxt_cnt = '0;
			end
		endcase
		// Supply loss overrides every window decision
		if (!supplyOk)
		begin
			nxt_state = ST_HOLD;
			nxt_cnt = '0;
			nxt_lowerEn = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff <= ST_HOLD;
			cnt_ff <= '0;
			lowerEn_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			lowerEn_ff <= nxt_lowerEn;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fault flags stick until the watchdog runs again
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			timeoutFlag <= 1'b0;
			earlyFlag <= 1'b0;
		end
		else if (nxt_state == ST_RUN)
		begin
			timeoutFlag <= 1'b0;
			earlyFlag <= 1'b0;
		end
		else
		begin
			timeoutFlag <= timeoutFlag | isTimeout;
			earlyFlag <= earlyFlag | isEarly;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset pin registered from next state, so decode glitches never reach it

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			resetOut_n <= 1'b0;
		else
			resetOut_n <= (nxt_state == ST_RUN);
	end
endmodule : wws_top
`default_nettype wire

// ### wws_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module wws_top_assertions
	import wws_pkg::*;
#(parameter int unsigned LONG_CYCLES = LONG_CYC)
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// Watched ports
	input wire logic        supplyOk,
	input wire logic        capMode,
	input wire logic [31:0] capFf,
	input wire logic        triggerInput,
	input wire logic        resetOut_n,
	input wire logic        timeoutFlag,
	input wire logic        earlyFlag,
	input wire logic        capRangeErr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [31:0] idle_ff;
	logic        trigQ_ff;
	// Idle span while released bounds how late a timeout may come
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			{idle_ff, trigQ_ff} <= 33'h0;
		else
			{idle_ff, trigQ_ff} <= {(resetOut_n && triggerInput == trigQ_ff) ?
				idle_ff + 32'h1 : 32'h0, triggerInput};
	sequence sHeld;
		!resetOut_n [*8];
	endsequence
	a_supply_low: assert property (!supplyOk |-> ##2 !resetOut_n) else $error("supply");
	a_return_held: assert property ($rose(supplyOk) |-> sHeld) else $error("return");
	a_fault_held: assert property ($fell(resetOut_n) |-> sHeld) else $error("held");
	a_timeout_rst: assert property ($rose(timeoutFlag) |-> ##[0:1] !resetOut_n) else $error("tmo");
	a_early_rst: assert property ($rose(earlyFlag) |-> ##[0:1] !resetOut_n) else $error("early");
	a_cap_range: assert property (capRangeErr ==
		$past(capMode && (capFf <= CAP_MIN_FF || capFf >= CAP_MAX_FF))) else $error("cap");
	a_high_ok: assert property (resetOut_n |-> $past(supplyOk)) else $error("high");
	a_idle_bound: assert property (idle_ff < LONG_CYCLES + 8) else $error("idle");
endmodule : wws_top_assertions
bind wws_top wws_top_assertions #(.LONG_CYCLES(LONG_CYCLES)) u_chk (.clk(clk), .arst_n(arst_n),
	.supplyOk(supplyOk), .capMode(capMode), .capFf(capFf), .triggerInput(triggerInput),
	.resetOut_n(resetOut_n), .timeoutFlag(timeoutFlag), .earlyFlag(earlyFlag),
	.capRangeErr(capRangeErr));
`default_nettype wire
